// ### hw/mbx_params.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses on paddr[11:0]
// Notes:   definitions only
`ifndef MBX_PARAMS_SVH
`define MBX_PARAMS_SVH

// Register byte offsets
`define MBX_OFF_CMD      12'h000
`define MBX_OFF_STATUS   12'h004
`define MBX_OFF_ACC      12'h008
`define MBX_OFF_PC       12'h00C
`define MBX_OFF_TBLHI    12'h010
`define MBX_OFF_WDOG     12'h014
`define MBX_OFF_CTRL     12'h018
`define MBX_MEM_WIN_SEL  4'h1

// Command word fields
`define MBX_CMD_OP_HI    29
`define MBX_CMD_OP_LO    24
`define MBX_CMD_BIT_HI   22
`define MBX_CMD_BIT_LO   20
`define MBX_CMD_IMM_HI   19
`define MBX_CMD_IMM_LO   12
`define MBX_CMD_ADR_HI   9
`define MBX_CMD_ADR_LO   0

// Status bit positions
`define MBX_ST_CARRY     0
`define MBX_ST_HALF      1
`define MBX_ST_ZERO      2
`define MBX_ST_WRAP      3
`define MBX_ST_SLEEP     4
`define MBX_ST_EXPIRY    5
`define MBX_ST_IRQEN     6

// Control bit positions
`define MBX_CTRL_WAKE    0
`define MBX_CTRL_BUSY    1

// Data memory address of the low program counter
`define MBX_PCL_ADDR     6'h06

// Reset values
`define MBX_PC_RST       10'h000
`define MBX_ACC_RST      8'h00

// Timing: system clocks per instruction cycle, base cycle counts
`define MBX_CLK_PER_CYC  4
`define MBX_CYC_SHORT    2'h1
`define MBX_CYC_LONG     2'h2

`endif

// ### hw/mbx_pkg.sv
// Purpose: shared types of the execution block
// Assumes: opcode values follow declaration order from zero
// Notes:   offsets and counts live in mbx_params.svh
package mbx_pkg;

    typedef enum logic [5:0] {
        NO_OP, DIRECT_JUMP, SKIP_IF_ZERO, SKIP_ZERO_COPY, SKIP_BIT_CLEAR,
        SKIP_IF_BIT_SET, INC_SKIP_ZERO, DEC_SKIP_ZERO, INC_SKIP_ZERO_TO_ACC,
        DEC_SKIP_ZERO_TO_ACC, SUB_CALL, SUBROUTINE_EXIT, SUBROUTINE_EXIT_IMM,
        INTERRUPT_EXIT, TABLE_FETCH_CURRENT_PAGE, TABLE_FETCH_FINAL_PAGE,
        BYTE_CLEAR, BYTE_SET, BIT_CLEAR, WATCHDOG_KICK, WATCHDOG_PREKICK_ONE,
        WATCHDOG_PREKICK_TWO, NIBBLE_EXCHANGE, NIBBLE_EXCHANGE_TO_ACC,
        POWER_DOWN, ADD_WITH_CARRY, ADD_WITH_CARRY_TO_MEMORY, SUM_MEM, SUM_IMM,
        SUM_TO_MEMORY, CONJ_MEM, CONJ_IMM, BITWISE_CONJ_TO_MEMORY
    } mbx_op_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPER, ST_HOLD, ST_APB, ST_APBDONE
    } mbx_state_t;

endpackage

// ### hw/mbx_mem_if.sv
// Purpose: data memory port between core and memory
// Assumes: read data registered, one cycle after address
// Notes:   write and read share one address
`timescale 1ns/1ps
`default_nettype none
interface mbx_mem_if;
    logic [5:0] addr;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ### hw/mbx_dmem.sv
// Purpose: data memory with registered read
// Assumes: read returns the old word on a same-cycle write
// Notes:   cleared at reset
`timescale 1ns/1ps
`default_nettype none
module mbx_dmem #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    // Memory port
    mbx_mem_if.mem      port
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] arr;
        logic [7:0]            rdata;
    } dmem_st_t;

    dmem_st_t st_ff;
    dmem_st_t nxt_st;

    if (DEPTH != 64) begin : g_chk
        $error("mbx_dmem: DEPTH must match the 6-bit address");
    end

    assign port.rdata = st_ff.rdata;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = st_ff.arr[port.addr];
        if (port.we) begin
            nxt_st.arr[port.addr] = port.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// ### hw/mbx_core.sv
// Purpose: executes one command word of the 8-bit instruction subset
// Assumes: APB slave, combinational program ROM answering within the same clock
// Notes:   one instruction cycle is four pclk periods
//
// What this block does
// - Test byte or bit, skip; copy variant loads acc
// - Inc/dec memory, write back, skip on zero
// - Inc/dec into acc, skip on zero, no flags
// - Taken skip adds one instruction cycle
// - Writing low program counter adds one cycle
// - Call pushes next address, jumps, two cycles
// - Exits pop stack in two cycles; immediate loads acc
// - Current-page table fetch to memory and high latch
// - Final-page table fetch, last program page
// - Kick clears watchdog, sleep and expiry flags
// - Both pre-kicks needed to clear; lone one records
// - Power-down stops, clears watchdog, sets sleep flag
// - Interrupt exit sets global interrupt enable
// - Add-with-carry into acc, four flags updated
// - Add-with-carry into memory, four flags updated
// - Plain add ignores carry, four flags updated
// - Conjunction to acc or memory, zero only
// - Bit clear and byte clear, no flags
// - Nibble exchange, acc form one cycle
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mbx_params.svh"
module mbx_core import mbx_pkg::*; #(
    parameter int PC_W        = 10,
    parameter int PROG_W      = 14,
    parameter int STACK_DEPTH = 2,
    parameter int WDT_W       = 8,
    parameter int PRESC_W     = 8
) (
    // Clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // APB slave
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    output logic     [31:0]         prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Program memory
    output logic     [PC_W-1:0]     prog_addr,
    input wire logic [PROG_W-1:0]   prog_data,
    // Power state
    output logic                    sleeping
);
    typedef struct packed {
        mbx_state_t                         state;
        logic                               pend;
        mbx_op_t                            op;
        logic [2:0]                         bsel;
        logic [7:0]                         imm;
        logic [PC_W-1:0]                    target;
        logic [7:0]                         acc;
        logic [PC_W-1:0]                    pc;
        logic [STACK_DEPTH-1:0][PC_W-1:0]   stack;
        logic [PROG_W-9:0]                  table_high_latch;
        logic                               c;
        logic                               hc;
        logic                               z;
        logic                               ov;
        logic                               sleep_flag;
        logic                               to;
        logic                               global_irq_enable;
        logic                               halted;
        logic                               pk1;
        logic                               pk2;
        logic [WDT_W-1:0]                   wdt;
        logic [PRESC_W-1:0]                 presc;
        logic [1:0]                         phase;
        logic [1:0]                         left;
        logic [31:0]                        prdata;
        logic                               pready;
        logic                               pslverr;
        logic [PC_W-1:0]                    prog_addr;
    } core_st_t;

    core_st_t           st_ff;
    core_st_t           nxt_st;
    mbx_mem_if          mem ();

    logic [7:0]         rd;
    logic [7:0]         res;
    logic [7:0]         opb;
    logic [8:0]         s9;
    logic [4:0]         s5;
    logic [1:0]         base;
    logic [PC_W-1:0]    npc;
    logic               wr_m;
    logic               skip;
    logic               pclw;
    logic               arith;
    logic               conj;
    logic               cin;
    logic               tick;
    logic               acc_ph;
    logic               memwin;
    logic               busy;

    if (PC_W < 9 || PROG_W < 9 || STACK_DEPTH < 1 || WDT_W < 1 || PRESC_W < 1)
    begin : g_chk
        $error("mbx_core: unsupported parameter values");
    end

    mbx_dmem #(.DEPTH(64)) u_dmem (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (mem.mem)
    );

    assign prdata    = st_ff.prdata;
    assign pready    = st_ff.pready;
    assign pslverr   = st_ff.pslverr;
    assign prog_addr = st_ff.prog_addr;
    assign sleeping  = st_ff.halted;

    always_comb begin
        nxt_st    = st_ff;
        mem.addr  = st_ff.target[5:0];
        mem.we    = 1'b0;
        mem.wdata = 8'h00;
        tick   = (st_ff.phase == 2'(`MBX_CLK_PER_CYC - 1));
        acc_ph = psel && penable;
        memwin = (paddr[11:8] == `MBX_MEM_WIN_SEL);
        busy   = st_ff.pend || (st_ff.state != ST_IDLE);
        // Operand fetch; low program counter reads back as a byte
        rd   = (st_ff.target[5:0] == `MBX_PCL_ADDR) ? st_ff.pc[7:0] : mem.rdata;
        opb  = (st_ff.op == SUM_IMM || st_ff.op == CONJ_IMM) ? st_ff.imm : rd;
        cin  = (st_ff.op == ADD_WITH_CARRY || st_ff.op == ADD_WITH_CARRY_TO_MEMORY)
               && st_ff.c;
        s9   = {1'b0, st_ff.acc} + {1'b0, opb} + {8'h00, cin};
        s5   = {1'b0, st_ff.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        res  = rd;
        base = `MBX_CYC_SHORT;
        npc  = st_ff.pc + PC_W'(1);
        wr_m  = 1'b0;
        skip  = 1'b0;
        pclw  = 1'b0;
        arith = 1'b0;
        conj  = 1'b0;

        // Instruction cycle divider
        nxt_st.phase = tick ? 2'h0 : st_ff.phase + 2'h1;

        // APB register path
        if (st_ff.pready) begin
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
            if (pwrite && !st_ff.pslverr && !memwin) begin
                if (paddr == `MBX_OFF_CMD) begin
                    nxt_st.op     = mbx_op_t'(pwdata[`MBX_CMD_OP_HI:`MBX_CMD_OP_LO]);
                    nxt_st.bsel   = pwdata[`MBX_CMD_BIT_HI:`MBX_CMD_BIT_LO];
                    nxt_st.imm    = pwdata[`MBX_CMD_IMM_HI:`MBX_CMD_IMM_LO];
                    nxt_st.target = PC_W'(pwdata[`MBX_CMD_ADR_HI:`MBX_CMD_ADR_LO]);
                    nxt_st.pend   = 1'b1;
                end else if (paddr == `MBX_OFF_STATUS) begin
                    nxt_st.c   = pwdata[`MBX_ST_CARRY];
                    nxt_st.hc  = pwdata[`MBX_ST_HALF];
                    nxt_st.z   = pwdata[`MBX_ST_ZERO];
                    nxt_st.ov  = pwdata[`MBX_ST_WRAP];
                    nxt_st.global_irq_enable = pwdata[`MBX_ST_IRQEN];
                end else if (paddr == `MBX_OFF_ACC) begin
                    nxt_st.acc = pwdata[7:0];
                end else if (paddr == `MBX_OFF_PC) begin
                    nxt_st.pc = pwdata[PC_W-1:0];
                end else if (paddr == `MBX_OFF_CTRL) begin
                    if (pwdata[`MBX_CTRL_WAKE]) begin
                        nxt_st.halted = 1'b0;
                    end
                end
            end
        end else if (acc_ph && !memwin) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata  = 32'h0000_0000;
            if (paddr == `MBX_OFF_CMD) begin
                nxt_st.pslverr = pwrite && busy;
                nxt_st.prdata  = {26'h0, st_ff.op};
            end else if (paddr == `MBX_OFF_STATUS) begin
                nxt_st.prdata = {25'h0, st_ff.global_irq_enable, st_ff.to, st_ff.sleep_flag, st_ff.ov,
                                 st_ff.z, st_ff.hc, st_ff.c};
            end else if (paddr == `MBX_OFF_ACC) begin
                nxt_st.prdata = {24'h0, st_ff.acc};
            end else if (paddr == `MBX_OFF_PC) begin
                nxt_st.pslverr = pwrite && busy;
                nxt_st.prdata  = 32'(st_ff.pc);
            end else if (paddr == `MBX_OFF_TBLHI) begin
                nxt_st.prdata = 32'(st_ff.table_high_latch);
            end else if (paddr == `MBX_OFF_WDOG) begin
                nxt_st.prdata = 32'(st_ff.wdt);
            end else if (paddr == `MBX_OFF_CTRL) begin
                nxt_st.prdata = {30'h0, busy, st_ff.halted};
            end else begin
                nxt_st.pslverr = 1'b1;
            end
        end

        case (st_ff.state)
            ST_IDLE: begin
                if (tick && st_ff.pend && !st_ff.halted) begin
                    nxt_st.pend  = 1'b0;
                    nxt_st.state = ST_OPER;
                    if (st_ff.op == TABLE_FETCH_FINAL_PAGE) begin
                        nxt_st.prog_addr = {{(PC_W-8){1'b1}}, st_ff.imm};
                    end else begin
                        nxt_st.prog_addr = {st_ff.pc[PC_W-1:8], st_ff.imm};
                    end
                end else if (acc_ph && memwin && !st_ff.pready) begin
                    mem.addr     = paddr[7:2];
                    nxt_st.state = ST_APB;
                end
            end
            ST_APB: begin
                nxt_st.prdata = {24'h0, mem.rdata};
                nxt_st.pready = 1'b1;
                nxt_st.state  = ST_APBDONE;
            end
            ST_APBDONE: begin
                mem.addr     = paddr[7:2];
                mem.we       = pwrite;
                mem.wdata    = pwdata[7:0];
                nxt_st.state = ST_IDLE;
            end
            ST_OPER: begin
                case (st_ff.op)
                    DIRECT_JUMP: begin
                        base = `MBX_CYC_LONG;
                        npc  = st_ff.target;
                    end
                    SKIP_IF_ZERO: skip = (rd == 8'h00);
                    SKIP_ZERO_COPY: begin
                        nxt_st.acc = rd;
                        skip       = (rd == 8'h00);
                    end
                    SKIP_BIT_CLEAR:  skip = !rd[st_ff.bsel];
                    SKIP_IF_BIT_SET: skip = rd[st_ff.bsel];
                    INC_SKIP_ZERO, DEC_SKIP_ZERO: begin
                        res  = (st_ff.op == INC_SKIP_ZERO) ? rd + 8'h01 : rd - 8'h01;
                        wr_m = 1'b1;
                        skip = (res == 8'h00);
                    end
                    INC_SKIP_ZERO_TO_ACC, DEC_SKIP_ZERO_TO_ACC: begin
                        res  = (st_ff.op == INC_SKIP_ZERO_TO_ACC) ? rd + 8'h01
                                                                   : rd - 8'h01;
                        nxt_st.acc = res;
                        skip       = (res == 8'h00);
                    end
                    SUB_CALL: begin
                        base = `MBX_CYC_LONG;
                        for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                            nxt_st.stack[i] = st_ff.stack[i-1];
                        end
                        nxt_st.stack[0] = st_ff.pc + PC_W'(1);
                        npc = st_ff.target;
                    end
                    SUBROUTINE_EXIT, SUBROUTINE_EXIT_IMM, INTERRUPT_EXIT: begin
                        base = `MBX_CYC_LONG;
                        npc  = st_ff.stack[0];
                        for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                            nxt_st.stack[i] = st_ff.stack[i+1];
                        end
                        nxt_st.stack[STACK_DEPTH-1] = '0;
                        if (st_ff.op == SUBROUTINE_EXIT_IMM) begin
                            nxt_st.acc = st_ff.imm;
                        end
                        if (st_ff.op == INTERRUPT_EXIT) begin
                            nxt_st.global_irq_enable = 1'b1;
                        end
                    end
                    TABLE_FETCH_CURRENT_PAGE, TABLE_FETCH_FINAL_PAGE: begin
                        base        = `MBX_CYC_LONG;
                        res         = prog_data[7:0];
                        wr_m        = 1'b1;
                        nxt_st.table_high_latch = prog_data[PROG_W-1:8];
                    end
                    BYTE_CLEAR: begin
                        res  = 8'h00;
                        wr_m = 1'b1;
                    end
                    BYTE_SET: begin
                        res  = 8'hFF;
                        wr_m = 1'b1;
                    end
                    BIT_CLEAR: begin
                        res[st_ff.bsel] = 1'b0;
                        wr_m            = 1'b1;
                    end
                    WATCHDOG_KICK: begin
                        nxt_st.wdt = '0;
                        nxt_st.sleep_flag = 1'b0;
                        nxt_st.to  = 1'b0;
                        nxt_st.pk1 = 1'b0;
                        nxt_st.pk2 = 1'b0;
                    end
                    WATCHDOG_PREKICK_ONE, WATCHDOG_PREKICK_TWO: begin
                        if ((st_ff.op == WATCHDOG_PREKICK_ONE) ? st_ff.pk2 : st_ff.pk1)
                        begin
                            nxt_st.wdt = '0;
                            nxt_st.sleep_flag = 1'b0;
                            nxt_st.to  = 1'b0;
                            nxt_st.pk1 = 1'b0;
                            nxt_st.pk2 = 1'b0;
                        end else if (st_ff.op == WATCHDOG_PREKICK_ONE) begin
                            nxt_st.pk1 = 1'b1;
                        end else begin
                            nxt_st.pk2 = 1'b1;
                        end
                    end
                    NIBBLE_EXCHANGE: begin
                        res  = {rd[3:0], rd[7:4]};
                        wr_m = 1'b1;
                    end
                    NIBBLE_EXCHANGE_TO_ACC: nxt_st.acc = {rd[3:0], rd[7:4]};
                    POWER_DOWN: begin
                        nxt_st.halted = 1'b1;
                        nxt_st.wdt    = '0;
                        nxt_st.presc  = '0;
                        nxt_st.sleep_flag    = 1'b1;
                        nxt_st.to     = 1'b0;
                    end
                    ADD_WITH_CARRY, SUM_MEM, SUM_IMM: begin
                        nxt_st.acc = s9[7:0];
                        arith      = 1'b1;
                    end
                    ADD_WITH_CARRY_TO_MEMORY, SUM_TO_MEMORY: begin
                        res   = s9[7:0];
                        wr_m  = 1'b1;
                        arith = 1'b1;
                    end
                    CONJ_MEM, CONJ_IMM: begin
                        nxt_st.acc = st_ff.acc & opb;
                        conj       = 1'b1;
                    end
                    BITWISE_CONJ_TO_MEMORY: begin
                        res  = st_ff.acc & opb;
                        wr_m = 1'b1;
                        conj = 1'b1;
                    end
                    default: ;
                endcase
                if (arith) begin
                    nxt_st.c  = s9[8];
                    nxt_st.hc = s5[4];
                    nxt_st.z  = (s9[7:0] == 8'h00);
                    nxt_st.ov = (st_ff.acc[7] == opb[7]) && (s9[7] != st_ff.acc[7]);
                end
                if (conj) begin
                    nxt_st.z = ((st_ff.acc & opb) == 8'h00);
                end
                pclw = wr_m && (st_ff.target[5:0] == `MBX_PCL_ADDR);
                if (wr_m && !pclw) begin
                    mem.we    = 1'b1;
                    mem.wdata = res;
                end
                if (pclw) begin
                    npc = {st_ff.pc[PC_W-1:8], res};
                end else if (skip) begin
                    npc = st_ff.pc + PC_W'(2);
                end
                nxt_st.pc    = npc;
                nxt_st.left  = base + {1'b0, pclw} + {1'b0, skip && !pclw};
                nxt_st.state = ST_HOLD;
            end
            ST_HOLD: begin
                if (tick) begin
                    nxt_st.left = st_ff.left - 2'h1;
                    if (st_ff.left == 2'h1) begin
                        nxt_st.state = ST_IDLE;
                    end
                end
            end
            default: nxt_st.state = ST_IDLE;
        endcase

        // Watchdog; time-out set wins over any clear
        if (tick) begin
            nxt_st.presc = st_ff.presc + PRESC_W'(1);
            if (&st_ff.presc) begin
                nxt_st.wdt = st_ff.wdt + WDT_W'(1);
                if (&st_ff.wdt) begin
                    nxt_st.to     = 1'b1;
                    nxt_st.halted = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff     <= '0;
            st_ff.pc  <= `MBX_PC_RST;
            st_ff.acc <= `MBX_ACC_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// ### testbench/mbx_core_asserts.sv
// Purpose: port checks of mbx_core
// Assumes: registers below 12'h100
// Notes: bound after endmodule
`timescale 1ns/1ps
`default_nettype none
module mbx_core_chk import mbx_pkg::*; #(parameter int PC_W = 10, parameter int PROG_W = 14) (
    // APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // ROM and power
    input wire logic [PC_W-1:0]   prog_addr,
    input wire logic [PROG_W-1:0] prog_data,
    input wire logic              sleeping
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic req;
    assign req = psel && penable && !pready;
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
    a_reg_answer: assert property (req && paddr[11:8] == 4'h0 |=> pready)
        else $error("late register answer");
    a_mem_answer: assert property (req && paddr[11:8] == 4'h1 |-> ##[1:60] pready)
        else $error("late memory answer");
    a_hole_error: assert property (req && paddr == 12'h01C |=> pslverr && prdata == 32'h0)
        else $error("hole not refused");
    a_sleep_hold: assert property (sleeping && $past(sleeping) |-> $stable(prog_addr))
        else $error("fetch while halted");
    a_reset_quiet: assert property ($rose(presetn) |-> !sleeping && prog_addr == 0)
        else $error("not quiet after reset");
    a_final_page: assert property (req && pwrite && paddr == 12'h000
        && pwdata[29:24] == TABLE_FETCH_FINAL_PAGE |-> ##[1:20] prog_addr[PC_W-1 -: 2] == 2'h3)
        else $error("final page missed");
    cover property (req && paddr[11:8] == 4'h1);
    cover property ($rose(sleeping));
    cover property (pready && pslverr);
endmodule
bind mbx_core mbx_core_chk #(.PC_W(PC_W), .PROG_W(PROG_W)) i_mbx_core_chk (.*);
`default_nettype wire

// ### testbench/mbx_rom_model.sv
// Purpose: program ROM beside mbx_core
// Assumes: word follows the address within the same cycle
// Notes: word is {addr[3:0], addr}
`timescale 1ns/1ps
`default_nettype none
module mbx_rom_model (
    // ROM port
    input wire logic [9:0]  addr,
    output logic     [13:0] data
);
    always_comb data = {addr[3:0], addr};
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: self-checking bench of mbx_core
// Assumes: default watchdog sizes, no expiry
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_count++; $display("BAD %0t mismatch got %h exp %h", $time, a, e); end end
module testbench import mbx_pkg::*; ;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, sleeping;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [9:0]  prog_addr;
    logic [13:0] prog_data;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    mbx_core i_mbx_core (.*);
    mbx_rom_model i_mbx_rom_model (.addr(prog_addr), .data(prog_data));
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 20000) begin
        err_count++;
        complete_run();
    end
    task automatic complete_run();
        $display("err_count %0d samples_checked %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic ck(input logic [11:0] a, input logic [9:0] e);
        apb(0, a, 0);
        `CHK(rd[9:0], e)
    endtask
    task automatic idle();
        do apb(0, 12'h018, 0); while (rd[1] !== 0);
    endtask
    task automatic run(input mbx_op_t op, input logic [2:0] b, input logic [7:0] x,
        input logic [9:0] m);
        idle();
        apb(1, 0, {2'h0, op, 1'h0, b, x, 2'h0, m});
        idle();
    endtask
    task automatic nap();
        idle();
        apb(1, 0, {2'h0, POWER_DOWN, 24'h0});
        while (sleeping !== 1) @(posedge pclk);
    endtask
    task automatic t_arith();
        apb(1, 12'h008, 32'h7F);
        apb(1, 12'h104, 32'h01);
        apb(1, 12'h004, 32'h01);
        run(SUM_MEM, 0, 0, 1);
        ck(12'h008, 10'h080);
        ck(12'h004, 10'h00A);
        apb(1, 12'h004, 32'h01);
        run(ADD_WITH_CARRY_TO_MEMORY, 0, 0, 1);
        ck(12'h104, 10'h082);
        run(ADD_WITH_CARRY, 0, 0, 1);
        ck(12'h008, 10'h002);
        ck(12'h004, 10'h009);
        run(CONJ_IMM, 0, 8'h01, 0);
        ck(12'h004, 10'h00D);
    endtask
    task automatic t_flow();
        apb(1, 12'h00C, 32'h010);
        run(SKIP_IF_ZERO, 0, 0, 2);
        ck(12'h00C, 10'h012);
        run(SUB_CALL, 0, 0, 10'h123);
        ck(12'h00C, 10'h123);
        run(SUBROUTINE_EXIT_IMM, 0, 8'h5A, 0);
        ck(12'h00C, 10'h013);
        ck(12'h008, 10'h05A);
        run(INTERRUPT_EXIT, 0, 0, 0);
        ck(12'h004, 10'h04D);
    endtask
    task automatic t_table();
        apb(1, 12'h00C, 32'h234);
        run(TABLE_FETCH_CURRENT_PAGE, 0, 8'h56, 3);
        ck(12'h10C, 10'h056);
        ck(12'h010, 10'h01A);
        run(TABLE_FETCH_FINAL_PAGE, 0, 8'h56, 3);
        ck(12'h010, 10'h01B);
    endtask
    task automatic t_sleep();
        nap();
        ck(12'h004, 10'h05D);
        ck(12'h018, 10'h001);
        apb(1, 12'h018, 32'h01);
        run(WATCHDOG_PREKICK_ONE, 0, 0, 0);
        ck(12'h004, 10'h05D);
        run(WATCHDOG_PREKICK_TWO, 0, 0, 0);
        ck(12'h004, 10'h04D);
        nap();
        apb(1, 12'h018, 32'h01);
        run(WATCHDOG_KICK, 0, 0, 0);
        ck(12'h004, 10'h04D);
        apb(0, 12'h01C, 0);
    endtask
    task automatic t_misc();
        apb(1, 12'h00C, 32'h1F0);
        run(BYTE_SET, 0, 0, 4);
        ck(12'h110, 10'h0FF);
        run(INC_SKIP_ZERO, 0, 0, 4);
        ck(12'h110, 10'h000);
        ck(12'h00C, 10'h1F3);
        run(BIT_CLEAR, 3'h7, 0, 1);
        ck(12'h104, 10'h002);
        run(NIBBLE_EXCHANGE_TO_ACC, 0, 0, 3);
        ck(12'h008, 10'h065);
        run(DEC_SKIP_ZERO_TO_ACC, 0, 0, 2);
        ck(12'h008, 10'h0FF);
        ck(12'h00C, 10'h1F6);
        run(BYTE_SET, 0, 0, 6);
        ck(12'h00C, 10'h1FF);
        ck(12'h004, 10'h04D);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_arith();
        t_flow();
        t_table();
        t_sleep();
        t_misc();
        complete_run();
    end
endmodule
`default_nettype wire
